// ### seven_segment_display_scanner.sv
// top: multiplexed four-digit display scanner feeding two cascaded sink drivers
`timescale 1ns/1ps
module seven_segment_display_scanner
  import scanner_pkg::*;
#(
  parameter int SHOW_TICK_COUNT = SHOW_TICKS
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        sample_tick,
  input  wire reading_type reading,
  input  wire logic        driver_serial_out,
  output logic [3:0]       param_index,
  output logic [2:0]       quantity_ind,
  output logic [2:0]       phase_ind,
  output logic             serial_clock,
  output logic             driver_serial_in,
  output logic             segment_latch_strobe,
  output logic             segment_output_enable_n,
  output logic             chain_mismatch
);

  if (SHOW_TICK_COUNT < 1) begin : g_bad_show
    $error("SHOW_TICK_COUNT must be at least 1");
  end

  localparam int SW = $clog2(SHOW_TICK_COUNT + 1);
  localparam int CW = $clog2(BIT_CYCLES + LATCH_HIGH_CYCLES);
  localparam int BW = $clog2(MSG_BITS + 1);

  typedef enum logic [2:0] {
    S_IDLE     = 3'b000,
    S_SHIFT    = 3'b001,
    S_LATCH_HI = 3'b010,
    S_LATCH_LO = 3'b011,
    S_ENABLE   = 3'b100
  } scan_state_type;

  // ----------------------------------------------------------------
  // parameter rotation
  // ----------------------------------------------------------------
  logic [SW-1:0] show_count_ff;
  logic [3:0]    param_ff;
  logic [2:0]    quantity_ff;
  logic [2:0]    phase_ff;

  wire show_wrap = sample_tick && (show_count_ff == SW'(SHOW_TICK_COUNT - 1));
  wire [3:0] nxt_param = (param_ff == 4'(PARAMS - 1)) ? 4'h0 : param_ff + 4'h1;
  // voltage 0..2, current 3..5, power factor 6..8, each R, Y, B
  wire [1:0] quantity_sel = (param_ff < 4'h3) ? 2'd0 : (param_ff < 4'h6) ? 2'd1 : 2'd2;
  wire [3:0] phase_sel    = param_ff - {quantity_sel, 1'b0} - {2'b00, quantity_sel};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      show_count_ff <= '0;
      param_ff      <= '0;
      quantity_ff   <= IND_FIRST;
      phase_ff      <= IND_FIRST;
    end else begin
      if (sample_tick) show_count_ff <= show_wrap ? '0 : show_count_ff + 1'b1;
      if (show_wrap) param_ff <= nxt_param;
      quantity_ff <= 3'(3'b001 << quantity_sel);
      phase_ff    <= 3'(3'b001 << phase_sel[1:0]);
    end
  end

  // ----------------------------------------------------------------
  // message source, one digit per sampling tick
  // ----------------------------------------------------------------
  logic [1:0]  digit_ff;
  logic        src_valid_ff;
  message_type src_msg_ff;
  logic        src_ready;

  // position code selects the digit from the left, pattern is the digit's value
  wire message_type nxt_msg = '{position: position_code(digit_ff),
                                segments: seg_pattern(reading.bcd[digit_ff],
                                                      reading.dot[digit_ff])};
  // a tick that finds the source still stalled is skipped, not queued
  wire take_tick = sample_tick && !src_valid_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      digit_ff     <= '0;
      src_valid_ff <= 1'b0;
      src_msg_ff   <= '0;
    end else begin
      if (take_tick) begin
        src_msg_ff   <= nxt_msg;
        src_valid_ff <= 1'b1;
        digit_ff     <= digit_ff + 2'd1;
      end else if (src_ready) begin
        src_valid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // buffer between source and serializer
  // ----------------------------------------------------------------
  logic            buf_valid;
  logic            buf_ready;
  logic [MSG_BITS-1:0] buf_data;

  message_buffer #(
    .WIDTH (MSG_BITS),
    .DEPTH (2)
  ) message_buffer_i (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (src_valid_ff),
    .in_ready  (src_ready),
    .in_data   (src_msg_ff),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  // ----------------------------------------------------------------
  // serializer and strobes
  // ----------------------------------------------------------------
  scan_state_type      state_ff;
  scan_state_type      nxt_state;
  logic [CW-1:0]       cyc_ff;
  logic [BW-1:0]       bit_cnt_ff;
  logic [MSG_BITS-1:0] shift_ff;
  logic                sclk_ff;
  logic                latch_ff;
  logic                oe_n_ff;
  logic                sdo_meta_ff;
  logic                sdo_sync_ff;
  logic [MSG_BITS-1:0] readback_ff;
  logic [MSG_BITS-1:0] prev_msg_ff;
  logic [MSG_BITS-1:0] cur_msg_ff;
  logic                prev_valid_ff;
  logic                mismatch_ff;

  wire in_shift = (state_ff == S_SHIFT);
  wire bit_end  = in_shift && (cyc_ff == CW'(BIT_CYCLES - 1));
  wire last_bit = bit_end && (bit_cnt_ff == BW'(MSG_BITS - 1));
  wire latch_end = (state_ff == S_LATCH_HI) && (cyc_ff == CW'(LATCH_HIGH_CYCLES - 1));
  assign buf_ready = (state_ff == S_IDLE);

  // one frame: sixteen bits, a two-cycle latch pulse, then the enable
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:     if (buf_valid) nxt_state = S_SHIFT;
      S_SHIFT:    if (last_bit) nxt_state = S_LATCH_HI;
      S_LATCH_HI: if (latch_end) nxt_state = S_LATCH_LO;
      S_LATCH_LO: nxt_state = S_ENABLE;
      S_ENABLE:   nxt_state = S_IDLE;
      default:    nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= S_IDLE;
      cyc_ff     <= '0;
      bit_cnt_ff <= '0;
      shift_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cyc_ff   <= (nxt_state != state_ff || bit_end) ? '0 : cyc_ff + 1'b1;
      if (state_ff == S_IDLE && buf_valid) begin
        shift_ff   <= buf_data;
        bit_cnt_ff <= '0;
      end else if (bit_end) begin
        shift_ff   <= {shift_ff[MSG_BITS-2:0], 1'b0};
        bit_cnt_ff <= bit_cnt_ff + 1'b1;
      end
    end
  end

  // clock low first half of each bit, data settled well before the rise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_ff  <= 1'b0;
      latch_ff <= 1'b0;
      oe_n_ff  <= 1'b1;
    end else begin
      sclk_ff  <= in_shift && (cyc_ff >= CW'(CLK_LOW_CYCLES));
      latch_ff <= (nxt_state == S_LATCH_HI);
      if (state_ff == S_LATCH_LO) oe_n_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // chain readback
  // ----------------------------------------------------------------
  // chain returns the previous frame; a differing readback flags a broken chain
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sdo_meta_ff   <= 1'b0;
      sdo_sync_ff   <= 1'b0;
      readback_ff   <= '0;
      prev_msg_ff   <= '0;
      cur_msg_ff    <= '0;
      prev_valid_ff <= 1'b0;
      mismatch_ff   <= 1'b0;
    end else begin
      sdo_meta_ff <= driver_serial_out;
      sdo_sync_ff <= sdo_meta_ff;
      if (bit_end) readback_ff <= {readback_ff[MSG_BITS-2:0], sdo_sync_ff};
      if (state_ff == S_LATCH_LO) begin
        mismatch_ff   <= prev_valid_ff && (readback_ff != prev_msg_ff);
        prev_msg_ff   <= cur_msg_ff;
        prev_valid_ff <= 1'b1;
      end
      if (state_ff == S_IDLE && buf_valid) cur_msg_ff <= buf_data;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // five wires to the chain: clock, data toward it, data back from it, latch strobe, output enable
  assign serial_clock            = sclk_ff;
  assign driver_serial_in        = shift_ff[MSG_BITS-1];
  assign segment_latch_strobe    = latch_ff;
  assign segment_output_enable_n = oe_n_ff;
  assign chain_mismatch          = mismatch_ff;
  assign param_index             = param_ff;
  assign quantity_ind            = quantity_ff;
  assign phase_ind               = phase_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [BW:0] rise_cnt_ff;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rise_cnt_ff <= '0;
    else if (state_ff == S_ENABLE) rise_cnt_ff <= '0;
    else if (!sclk_ff && in_shift && cyc_ff >= CW'(CLK_LOW_CYCLES)) rise_cnt_ff <= rise_cnt_ff + 1'b1;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_sclk_idle_low: assert property (state_ff == S_IDLE |-> !sclk_ff)
    else $error("serial clock high while idle");
  a_pos_one_hot: assert property (src_valid_ff |-> $onehot(src_msg_ff.position[7:4])
                                  && src_msg_ff.position[3:0] == 4'h0)
    else $error("position byte not one-hot");
  a_sixteen_edges: assert property ($rose(latch_ff) |-> rise_cnt_ff == (BW+1)'(MSG_BITS))
    else $error("latch without sixteen clock edges");
  a_latch_then_oe: assert property (last_bit |-> ##2 latch_ff ##[1:4] !latch_ff ##1 !oe_n_ff)
    else $error("latch or enable out of order");
  a_param_wrap: assert property (show_wrap && param_ff == 4'(PARAMS - 1) |=> param_ff == 4'h0)
    else $error("parameter sequence does not wrap");
  a_show_time: assert property ($changed(param_ff) |-> $past(show_count_ff) == SW'(SHOW_TICK_COUNT - 1))
    else $error("parameter changed early");
  a_tick_digit: assert property (take_tick |=> src_valid_ff
                                 && src_msg_ff.position == position_code($past(digit_ff)))
    else $error("tick did not issue the next digit");
  a_no_shift_latch: assert property (in_shift |-> !latch_ff)
    else $error("latch high while shifting");

  // ----------------------------------------------------------------
  // checks on indicators, strobes and readback
  // ----------------------------------------------------------------
  // indicators lag the parameter by one cycle
  a_ind_one_hot: assert property ($onehot(quantity_ff) && $onehot(phase_ff))
    else $error("indicator not one-hot");
  a_ind_follows: assert property (1'b1 |=> quantity_ff[2] == ($past(param_ff) > 4'h5)
                                  && phase_ff[0] == ($past(param_ff) % 4'h3 == 4'h0))
    else $error("indicator does not match parameter");
  a_load_msb_first: assert property (state_ff == S_IDLE && buf_valid |=> shift_ff == $past(buf_data))
    else $error("frame not loaded position first");
  a_data_holds_rise: assert property ($rose(sclk_ff) |-> $stable(shift_ff))
    else $error("data moved at the clock rise");
  // enable goes low only right after a latch pulse and never returns high
  a_oe_after_latch: assert property ($fell(oe_n_ff) |-> $past(state_ff) == S_LATCH_LO)
    else $error("enable low before latch");
  a_oe_stays_on: assert property (!oe_n_ff |=> !oe_n_ff)
    else $error("enable raised after start");
  // the first frame after reset has nothing to compare against
  a_first_unchecked: assert property (state_ff == S_LATCH_LO && !prev_valid_ff |=> !mismatch_ff)
    else $error("first frame flagged as mismatch");

endmodule // seven_segment_display_scanner

// ### scanner_pkg.sv
// shared constants, types and encoders for the seven-segment display scanner
package scanner_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ          = 40_000_000;
  localparam int SERIAL_BPS        = 9_000_000;
  // least bit time rounds up: 5 cycles, so the link runs at 8 Mbps
  localparam int BIT_CYCLES        = (CLOCK_HZ + SERIAL_BPS - 1) / SERIAL_BPS;
  localparam int CLK_LOW_CYCLES    = BIT_CYCLES - BIT_CYCLES / 2;
  localparam int TICKS_PER_SECOND  = 4096;
  localparam int SHOW_SECONDS      = 4;
  localparam int SHOW_TICKS        = TICKS_PER_SECOND * SHOW_SECONDS;
  localparam int LATCH_HIGH_CYCLES = 2;

  // ----------------------------------------------------------------
  // message layout
  // ----------------------------------------------------------------
  localparam int DIGITS   = 4;
  localparam int PARAMS   = 9;
  localparam int MSG_BITS = 16;
  localparam int DP_BIT   = 0;

  localparam logic [7:0] POS_DIGIT1 = 8'h80;
  localparam logic [7:0] POS_DIGIT2 = 8'h40;
  localparam logic [7:0] POS_DIGIT3 = 8'h20;
  localparam logic [7:0] POS_DIGIT4 = 8'h10;

  localparam logic [7:0] SEG_0     = 8'hFC;
  localparam logic [7:0] SEG_1     = 8'h60;
  localparam logic [7:0] SEG_2     = 8'hDA;
  localparam logic [7:0] SEG_3     = 8'hF2;
  localparam logic [7:0] SEG_4     = 8'h66;
  localparam logic [7:0] SEG_5     = 8'hB6;
  localparam logic [7:0] SEG_6     = 8'hBE;
  localparam logic [7:0] SEG_7     = 8'hE0;
  localparam logic [7:0] SEG_8     = 8'hFE;
  localparam logic [7:0] SEG_9     = 8'hF6;
  localparam logic [7:0] SEG_BLANK = 8'h00;

  localparam logic [2:0] IND_FIRST = 3'b001;

  // position byte goes out first, segment byte second
  typedef struct packed {
    logic [7:0] position;
    logic [7:0] segments;
  } message_type;

  // bcd[0] and dot[0] belong to the leftmost digit
  typedef struct packed {
    logic [3:0][3:0] bcd;
    logic [3:0]      dot;
  } reading_type;

  function automatic logic [7:0] position_code(input logic [1:0] idx);
    case (idx)
      2'd0:    position_code = POS_DIGIT1;
      2'd1:    position_code = POS_DIGIT2;
      2'd2:    position_code = POS_DIGIT3;
      default: position_code = POS_DIGIT4;
    endcase
  endfunction

  // set bit lights a segment: bit 7 is A down to bit 1 as G, bit 0 the point
  function automatic logic [7:0] seg_pattern(input logic [3:0] bcd, input logic dot);
    logic [7:0] p;
    case (bcd)
      4'h0:    p = SEG_0;
      4'h1:    p = SEG_1;
      4'h2:    p = SEG_2;
      4'h3:    p = SEG_3;
      4'h4:    p = SEG_4;
      4'h5:    p = SEG_5;
      4'h6:    p = SEG_6;
      4'h7:    p = SEG_7;
      4'h8:    p = SEG_8;
      4'h9:    p = SEG_9;
      default: p = SEG_BLANK;
    endcase
    p[DP_BIT] = p[DP_BIT] | dot;
    return p;
  endfunction

endpackage

// ### message_buffer.sv
// small valid/ready buffer holding display messages ahead of the serializer
`timescale 1ns/1ps
module message_buffer
  import scanner_pkg::*;
#(
  parameter int WIDTH = MSG_BITS,
  parameter int DEPTH = 2
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("message_buffer depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] store_ff [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [PW:0]      count_ff;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count_ff != (PW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data  = store_ff[rd_ptr_ff];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // payload needs no reset: it is only read while counted valid
  always_ff @(posedge clock) begin
    if (push) store_ff[wr_ptr_ff] <= in_data;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_buf_no_overflow: assert property (count_ff <= (PW+1)'(DEPTH))
    else $error("buffer accepts while full");
  a_buf_keeps_word: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled word lost");

endmodule // message_buffer

// ### driver_chain_model.sv
// behavioural model of the two cascaded serial-in sink drivers
`timescale 1ns/1ps
module driver_chain_model (
  input  wire logic        serial_clock,
  input  wire logic        driver_serial_in,
  input  wire logic        segment_latch_strobe,
  input  wire logic        flip_out,
  output logic             driver_serial_out,
  output logic      [15:0] shown
);
  // ----------------------------------------------------------------
  // shift chain and output latch
  // ----------------------------------------------------------------
  // power-up contents are arbitrary, so start from a non-zero pattern
  logic [15:0] chain_ff = 16'h5a3c;

  // first byte shifted in ends at the far (digit select) end
  always @(posedge serial_clock) begin
    chain_ff <= {chain_ff[14:0], driver_serial_in};
  end

  // flip_out lets the bench corrupt the readback on purpose
  assign driver_serial_out = chain_ff[15] ^ flip_out;

  // transparent latch: outputs follow the chain only while strobe is high
  always @* begin
    if (segment_latch_strobe) begin
      shown = chain_ff;
    end
  end
endmodule // driver_chain_model

// ### seven_segment_display_scanner_test.sv
// self-checking testbench for the seven-segment display scanner
`timescale 1ns/1ps
module seven_segment_display_scanner_test;
  import scanner_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam int SHOW = 4;
  localparam logic [7:0] SEG_TAB [10] = '{SEG_0, SEG_1, SEG_2, SEG_3, SEG_4,
                                          SEG_5, SEG_6, SEG_7, SEG_8, SEG_9};
  logic        clock       = 1'b0;
  logic        rst_n       = 1'b0;
  logic        sample_tick = 1'b0;
  reading_type reading     = '0;
  logic        flip_out    = 1'b0;
  logic [3:0]  param_index;
  logic [2:0]  quantity_ind;
  logic [2:0]  phase_ind;
  logic        serial_clock;
  logic        driver_serial_in;
  logic        driver_serial_out;
  logic        segment_latch_strobe;
  logic        segment_output_enable_n;
  logic        chain_mismatch;
  logic [15:0] shown;
  logic [15:0] notes[$];
  int          err_count = 0;
  int          tests_run = 0;
  int          ticks     = 0;
  int          rises     = 0;
  integer      seed      = 32'hef76;
  realtime     last_rise = 0.0;

  always #12.5 clock = ~clock;

  seven_segment_display_scanner #(.SHOW_TICK_COUNT(SHOW)) seven_segment_display_scanner_i (
    .clock                   (clock),
    .rst_n                   (rst_n),
    .sample_tick             (sample_tick),
    .reading                 (reading),
    .driver_serial_out       (driver_serial_out),
    .param_index             (param_index),
    .quantity_ind            (quantity_ind),
    .phase_ind               (phase_ind),
    .serial_clock            (serial_clock),
    .driver_serial_in        (driver_serial_in),
    .segment_latch_strobe    (segment_latch_strobe),
    .segment_output_enable_n (segment_output_enable_n),
    .chain_mismatch          (chain_mismatch)
  );

  driver_chain_model driver_chain_model_i (
    .serial_clock         (serial_clock),
    .driver_serial_in     (driver_serial_in),
    .segment_latch_strobe (segment_latch_strobe),
    .flip_out             (flip_out),
    .driver_serial_out    (driver_serial_out),
    .shown                (shown)
  );

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one tick: check idle state and indicators, note the expected frame, pulse
  task automatic send_tick(input int gap);
    logic [31:0] rnd;
    reading_type r;
    int          d;
    int          idx;
    logic [7:0]  seg;
    rnd = $random(seed);
    r   = rnd[19:0];
    d   = ticks % DIGITS;
    idx = (ticks / SHOW) % PARAMS;
    @(negedge clock);
    check({15'h0, serial_clock}, 16'h0000);
    check({12'h0, param_index}, 16'(idx));
    check({13'h0, quantity_ind}, 16'(1 << (idx / 3)));
    check({13'h0, phase_ind}, 16'(1 << (idx % 3)));
    seg = (r.bcd[d] < 4'ha) ? SEG_TAB[r.bcd[d]] : 8'h00;
    seg[0] = seg[0] | r.dot[d];
    notes.push_back({8'(POS_DIGIT1 >> d), seg});
    @(posedge clock);
    reading     <= r;
    sample_tick <= 1'b1;
    @(posedge clock);
    sample_tick <= 1'b0;
    ticks++;
    repeat (gap) @(posedge clock);
  endtask

  // frame is complete when the latch strobe falls
  always @(negedge segment_latch_strobe) begin
    if (rst_n) begin
      check(16'(notes.size() != 0), 16'h0001);
      if (notes.size() != 0) begin
        check(shown, notes.pop_front());
      end
      check(16'(rises), 16'h0010);
      rises = 0;
      repeat (2) @(negedge clock);
      check({15'h0, segment_output_enable_n}, 16'h0000);
    end
  end

  always @(posedge serial_clock) begin
    if (rises > 0) begin
      check(16'(int'(($realtime - last_rise) / 25.0)), 16'(BIT_CYCLES));
    end
    last_rise = $realtime;
    rises++;
  end

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    check({13'h0, segment_output_enable_n, segment_latch_strobe, serial_clock},
          16'h0004);
    rst_n <= 1'b1;
    @(posedge clock);
    // forty ticks walk all nine parameters and wrap to the first
    for (int k = 0; k < 40; k++) begin
      send_tick(90 + int'($unsigned($random(seed)) % 32));
    end
    $display("scan and parameter walk done");
    // two ticks close together must both reach the drivers
    send_tick(4);
    send_tick(200);
    $display("close ticks done");
    check({15'h0, chain_mismatch}, 16'h0000);
    flip_out <= 1'b1;
    send_tick(120);
    flip_out <= 1'b0;
    check({15'h0, chain_mismatch}, 16'h0001);
    send_tick(120);
    check({15'h0, chain_mismatch}, 16'h0000);
    $display("readback done");
    rst_n <= 1'b0;
    @(posedge clock);
    check({13'h0, segment_output_enable_n, segment_latch_strobe, serial_clock},
          16'h0004);
    ticks = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check({15'h0, segment_output_enable_n}, 16'h0001);
    for (int k = 0; k < 5; k++) begin
      send_tick(110);
    end
    $display("second reset done");
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    report_and_stop();
  end
endmodule // seven_segment_display_scanner_test
